/* File: hw/cfpb_pkg.sv */
// Constants and types for the configuration fuse protection bank.
// Assumes byte registers are indexed by printed offset; APB byte address is four times that.
package cfpb_pkg;
	// Register indexes
	localparam logic [21:0] IDX_MUX = 22'h30_0005;
	localparam logic [21:0] IDX_DBG = 22'h30_0006;
	localparam logic [21:0] IDX_CPL = 22'h30_0008;
	localparam logic [21:0] IDX_CPH = 22'h30_0009;
	localparam logic [21:0] IDX_WPL = 22'h30_000a;
	localparam logic [21:0] IDX_WPH = 22'h30_000b;
	localparam logic [21:0] IDX_TRL = 22'h30_000c;
	localparam logic [21:0] IDX_TRH = 22'h30_000d;
	localparam logic [21:0] IDX_ID = 22'h3f_fffe;
	// Implemented bits; also the unprogrammed reset value
	localparam logic [7:0] MASK_MUX = 8'h01;
	localparam logic [7:0] MASK_DBG = 8'h85;
	localparam logic [7:0] MASK_LOW = 8'h0f;
	localparam logic [7:0] MASK_CPH = 8'hc0;
	localparam logic [7:0] MASK_WPH = 8'he0;
	localparam logic [7:0] MASK_TRH = 8'h40;
	// Field positions
	localparam int DBG_BIT = 7;
	localparam int LOWV_BIT = 2;
	localparam int STV_BIT = 0;
	localparam int EEP_BIT = 7;
	localparam int BOOT_BIT = 6;
	localparam int CFG_BIT = 5;
	localparam int MUX_BIT = 0;
	localparam int REV_W = 5;
	localparam int PART_W = 3;
	// Region limits
	localparam logic [21:0] BOOT_END = 22'h00_07ff;
	localparam logic [21:0] R0_END = 22'h00_3fff;
	localparam logic [21:0] R1_END = 22'h00_7fff;
	localparam logic [21:0] R2_END = 22'h00_bfff;
	localparam logic [21:0] R3_END = 22'h00_ffff;
	localparam logic [21:0] CFG_LO = 22'h30_0000;
	localparam logic [21:0] CFG_HI = 22'h30_00ff;
	localparam logic [1:0] MODE_MCU = 2'h3;
	typedef enum logic [2:0] {RG_0, RG_1, RG_2, RG_3, RG_BOOT, RG_EEP, RG_CFG, RG_NONE}
		cfpb_region_type;
	typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_TABLE, ACC_RSVD} cfpb_acc_type;
	typedef enum logic {ST_LOAD, ST_RUN} cfpb_state_type;
endpackage

/* File: hw/cfpb_bank.sv */
// Configuration fuse protection bank: fuse-loaded option and protection bytes,
// APB register access and per-access protection check.
// Assumes fuse levels are stable from reset release; APB master per AMBA APB4.
// Operation
// - Regions zero to two span 000800-003FFF, 004000-007FFF, 008000-00BFFF.
// - Boot region 000000-0007FF and region three 00C000-00FFFF have own bits.
// - Low code-protect bit N at 0 read-protects region N; bits 7-4 unused.
// - High code-protect bit 7 at 0 read-protects the data EEPROM.
// - High code-protect bit 6 at 0 protects boot; bits 5-0 read zero.
// - Low write-protect bit N at 0 blocks writes to region N.
// - High write-protect bit 7 blocks EEPROM, bit 6 blocks boot writes.
// - High write-protect bit 5 blocks config space writes; bits 4-0 read zero.
// - Table-read bit N at 0 refuses reads of region N from other regions.
// - Table-read high bit 6 guards boot likewise; other bits read zero.
// - Protection bits are one when blank and can only be cleared.
// - Option bit 7 at 0 enables debugger and claims port B pins 6 and 7.
// - Option bit 2 at 1 enables low-voltage programming entry.
// - Option bit 0 at 1 resets on stack fault; bits 6-3, 1 read zero.
// - External-memory modes route capture unit two to port C1 or B3.
// - Read-only id byte: part code in bits 7-5, revision in 4-0.
// - Microcontroller mode routes capture unit two to port C1 or E7.
`timescale 1ns/10ps
`default_nettype none
module cfpb_bank #(
	parameter logic [2:0] PART_CODE = 3'h3, // Value is arbitrary
	parameter logic [4:0] REVISION = 5'h01 // Value is arbitrary
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [23:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [7:0] fuse_capture2_mux_i,
	input wire logic [7:0] fuse_debug_option_i,
	input wire logic [7:0] fuse_code_protect_low_i,
	input wire logic [7:0] fuse_code_protect_high_i,
	input wire logic [7:0] fuse_write_protect_low_i,
	input wire logic [7:0] fuse_write_protect_high_i,
	input wire logic [7:0] fuse_table_read_protect_low_i,
	input wire logic [7:0] fuse_table_read_protect_high_i,
	input wire logic acc_valid_i,
	input wire logic [1:0] acc_kind_i,
	input wire logic acc_eeprom_i,
	input wire logic [21:0] acc_addr_i,
	input wire logic [21:0] exec_addr_i,
	output logic acc_done_o,
	output logic acc_grant_o,
	input wire logic [1:0] proc_mode_i,
	input wire logic stack_fault_i,
	output logic config_loaded_o,
	output logic debug_enable_o,
	output logic portb_pin67_debug_o,
	output logic low_voltage_prog_enable_o,
	output logic stack_fault_reset_enable_o,
	output logic stack_reset_o,
	output logic capture2_portc_pin1_o,
	output logic capture2_portb_pin3_o,
	output logic capture2_porte_pin7_o
);
	cfpb_pkg::cfpb_state_type state_q;
	logic [7:0] capture2_mux_q;
	logic [7:0] debug_option_config_q;
	logic [7:0] code_protect_low_q;
	logic [7:0] code_protect_high_q;
	logic [7:0] write_protect_low_q;
	logic [7:0] write_protect_high_q;
	logic [7:0] table_read_protect_low_q;
	logic [7:0] table_read_protect_high_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic acc_done_q;
	logic acc_grant_q;
	logic [21:0] reg_idx;
	logic [8:0] rd_sel;
	logic bus_err;
	logic wr_take;
	logic acc_ok;
	cfpb_pkg::cfpb_region_type tgt_rg;
	cfpb_pkg::cfpb_region_type exe_rg;

	// Region decode of a program-memory address
	function automatic cfpb_pkg::cfpb_region_type region_of(input logic [21:0] a);
		if (a <= cfpb_pkg::BOOT_END) begin
			region_of = cfpb_pkg::RG_BOOT;
		end else if (a <= cfpb_pkg::R0_END) begin
			region_of = cfpb_pkg::RG_0;
		end else if (a <= cfpb_pkg::R1_END) begin
			region_of = cfpb_pkg::RG_1;
		end else if (a <= cfpb_pkg::R2_END) begin
			region_of = cfpb_pkg::RG_2;
		end else if (a <= cfpb_pkg::R3_END) begin
			region_of = cfpb_pkg::RG_3;
		end else if (a >= cfpb_pkg::CFG_LO && a <= cfpb_pkg::CFG_HI) begin
			region_of = cfpb_pkg::RG_CFG;
		end else begin
			region_of = cfpb_pkg::RG_NONE;
		end
	endfunction

	// Programming may only clear implemented bits
	function automatic logic [7:0] clear_only(input logic [7:0] old, input logic [7:0] wd,
			input logic [7:0] mask);
		clear_only = old & wd & mask;
	endfunction

	// Read data with hit flag; unimplemented bits read zero
	function automatic logic [8:0] read_sel(input logic [21:0] idx);
		unique case (idx)
			cfpb_pkg::IDX_MUX: read_sel = {1'b1, capture2_mux_q};
			cfpb_pkg::IDX_DBG: read_sel = {1'b1, debug_option_config_q};
			cfpb_pkg::IDX_CPL: read_sel = {1'b1, code_protect_low_q};
			cfpb_pkg::IDX_CPH: read_sel = {1'b1, code_protect_high_q};
			cfpb_pkg::IDX_WPL: read_sel = {1'b1, write_protect_low_q};
			cfpb_pkg::IDX_WPH: read_sel = {1'b1, write_protect_high_q};
			cfpb_pkg::IDX_TRL: read_sel = {1'b1, table_read_protect_low_q};
			cfpb_pkg::IDX_TRH: read_sel = {1'b1, table_read_protect_high_q};
			cfpb_pkg::IDX_ID: read_sel = {1'b1, PART_CODE, REVISION};
			default: read_sel = 9'h000;
		endcase
	endfunction

	assign reg_idx = paddr_i[23:2];
	always_comb begin
		rd_sel = read_sel(reg_idx);
	end
	// Unmapped, id writes and locked config writes are errors
	assign bus_err = !rd_sel[8] || (pwrite_i && reg_idx == cfpb_pkg::IDX_ID)
		|| (pwrite_i && !write_protect_high_q[cfpb_pkg::CFG_BIT]);
	assign wr_take = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q && pstrb_i[0];

	// Fuse load sequence
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			state_q <= cfpb_pkg::ST_LOAD;
		end else begin
			state_q <= cfpb_pkg::ST_RUN;
		end
	end

	// Configuration bytes
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			capture2_mux_q <= cfpb_pkg::MASK_MUX;
			debug_option_config_q <= cfpb_pkg::MASK_DBG;
			code_protect_low_q <= cfpb_pkg::MASK_LOW;
			code_protect_high_q <= cfpb_pkg::MASK_CPH;
			write_protect_low_q <= cfpb_pkg::MASK_LOW;
			write_protect_high_q <= cfpb_pkg::MASK_WPH;
			table_read_protect_low_q <= cfpb_pkg::MASK_LOW;
			table_read_protect_high_q <= cfpb_pkg::MASK_TRH;
		end else if (state_q == cfpb_pkg::ST_LOAD) begin
			capture2_mux_q <= fuse_capture2_mux_i & cfpb_pkg::MASK_MUX;
			debug_option_config_q <= fuse_debug_option_i & cfpb_pkg::MASK_DBG;
			code_protect_low_q <= fuse_code_protect_low_i & cfpb_pkg::MASK_LOW;
			code_protect_high_q <= fuse_code_protect_high_i & cfpb_pkg::MASK_CPH;
			write_protect_low_q <= fuse_write_protect_low_i & cfpb_pkg::MASK_LOW;
			write_protect_high_q <= fuse_write_protect_high_i & cfpb_pkg::MASK_WPH;
			table_read_protect_low_q <= fuse_table_read_protect_low_i & cfpb_pkg::MASK_LOW;
			table_read_protect_high_q <= fuse_table_read_protect_high_i & cfpb_pkg::MASK_TRH;
		end else if (wr_take) begin
			case (reg_idx)
				cfpb_pkg::IDX_MUX: capture2_mux_q <= pwdata_i[7:0] & cfpb_pkg::MASK_MUX;
				cfpb_pkg::IDX_DBG: debug_option_config_q <= pwdata_i[7:0] & cfpb_pkg::MASK_DBG;
				cfpb_pkg::IDX_CPL: code_protect_low_q <=
					clear_only(code_protect_low_q, pwdata_i[7:0], cfpb_pkg::MASK_LOW);
				cfpb_pkg::IDX_CPH: code_protect_high_q <=
					clear_only(code_protect_high_q, pwdata_i[7:0], cfpb_pkg::MASK_CPH);
				cfpb_pkg::IDX_WPL: write_protect_low_q <=
					clear_only(write_protect_low_q, pwdata_i[7:0], cfpb_pkg::MASK_LOW);
				cfpb_pkg::IDX_WPH: write_protect_high_q <=
					clear_only(write_protect_high_q, pwdata_i[7:0], cfpb_pkg::MASK_WPH);
				cfpb_pkg::IDX_TRL: table_read_protect_low_q <=
					clear_only(table_read_protect_low_q, pwdata_i[7:0], cfpb_pkg::MASK_LOW);
				cfpb_pkg::IDX_TRH: table_read_protect_high_q <=
					clear_only(table_read_protect_high_q, pwdata_i[7:0], cfpb_pkg::MASK_TRH);
				default: ;
			endcase
		end
	end

	// APB slave: answer one cycle after a request is seen
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (pready_q) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (psel_i && state_q == cfpb_pkg::ST_RUN) begin
			pready_q <= 1'b1;
			pslverr_q <= bus_err;
			prdata_q <= {24'h00_0000, rd_sel[7:0]};
		end
	end

	// Protection check of one access
	assign tgt_rg = acc_eeprom_i ? cfpb_pkg::RG_EEP : region_of(acc_addr_i);
	assign exe_rg = region_of(exec_addr_i);
	always_comb begin
		acc_ok = 1'b1;
		unique case (cfpb_pkg::cfpb_acc_type'(acc_kind_i))
			cfpb_pkg::ACC_READ: begin
				unique case (tgt_rg)
					cfpb_pkg::RG_0, cfpb_pkg::RG_1, cfpb_pkg::RG_2, cfpb_pkg::RG_3:
						acc_ok = code_protect_low_q[tgt_rg[1:0]];
					cfpb_pkg::RG_BOOT: acc_ok = code_protect_high_q[cfpb_pkg::BOOT_BIT];
					cfpb_pkg::RG_EEP: acc_ok = code_protect_high_q[cfpb_pkg::EEP_BIT];
					default: acc_ok = 1'b1;
				endcase
			end
			cfpb_pkg::ACC_WRITE: begin
				unique case (tgt_rg)
					cfpb_pkg::RG_0, cfpb_pkg::RG_1, cfpb_pkg::RG_2, cfpb_pkg::RG_3:
						acc_ok = write_protect_low_q[tgt_rg[1:0]];
					cfpb_pkg::RG_BOOT: acc_ok = write_protect_high_q[cfpb_pkg::BOOT_BIT];
					cfpb_pkg::RG_EEP: acc_ok = write_protect_high_q[cfpb_pkg::EEP_BIT];
					cfpb_pkg::RG_CFG: acc_ok = write_protect_high_q[cfpb_pkg::CFG_BIT];
					default: acc_ok = 1'b1;
				endcase
			end
			cfpb_pkg::ACC_TABLE: begin
				if (tgt_rg == exe_rg) begin
					acc_ok = 1'b1;
				end else begin
					unique case (tgt_rg)
						cfpb_pkg::RG_0, cfpb_pkg::RG_1, cfpb_pkg::RG_2, cfpb_pkg::RG_3:
							acc_ok = table_read_protect_low_q[tgt_rg[1:0]];
						cfpb_pkg::RG_BOOT:
							acc_ok = table_read_protect_high_q[cfpb_pkg::BOOT_BIT];
						default: acc_ok = 1'b1;
					endcase
				end
			end
			cfpb_pkg::ACC_RSVD: acc_ok = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			acc_done_q <= 1'b0;
			acc_grant_q <= 1'b0;
		end else begin
			acc_done_q <= acc_valid_i && state_q == cfpb_pkg::ST_RUN;
			acc_grant_q <= acc_valid_i && state_q == cfpb_pkg::ST_RUN && acc_ok;
		end
	end

	// Option and pin routing outputs
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			config_loaded_o <= 1'b0;
			debug_enable_o <= 1'b0;
			portb_pin67_debug_o <= 1'b0;
			low_voltage_prog_enable_o <= 1'b0;
			stack_fault_reset_enable_o <= 1'b0;
			stack_reset_o <= 1'b0;
			capture2_portc_pin1_o <= 1'b0;
			capture2_portb_pin3_o <= 1'b0;
			capture2_porte_pin7_o <= 1'b0;
		end else begin
			config_loaded_o <= state_q == cfpb_pkg::ST_RUN;
			debug_enable_o <= !debug_option_config_q[cfpb_pkg::DBG_BIT];
			portb_pin67_debug_o <= !debug_option_config_q[cfpb_pkg::DBG_BIT];
			low_voltage_prog_enable_o <= debug_option_config_q[cfpb_pkg::LOWV_BIT];
			stack_fault_reset_enable_o <= debug_option_config_q[cfpb_pkg::STV_BIT];
			stack_reset_o <= stack_fault_i && debug_option_config_q[cfpb_pkg::STV_BIT];
			capture2_portc_pin1_o <= capture2_mux_q[cfpb_pkg::MUX_BIT];
			capture2_portb_pin3_o <= !capture2_mux_q[cfpb_pkg::MUX_BIT]
				&& proc_mode_i != cfpb_pkg::MODE_MCU;
			capture2_porte_pin7_o <= !capture2_mux_q[cfpb_pkg::MUX_BIT]
				&& proc_mode_i == cfpb_pkg::MODE_MCU;
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign acc_done_o = acc_done_q;
	assign acc_grant_o = acc_grant_q;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	prot_clear_only_a: assert property ($past(state_q) == cfpb_pkg::ST_RUN |->
		(code_protect_low_q & ~$past(code_protect_low_q)) == 8'h00
		&& (write_protect_high_q & ~$past(write_protect_high_q)) == 8'h00)
		else $error("protection bit was set after load");
	no_early_access_a: assert property (state_q == cfpb_pkg::ST_LOAD |=> !acc_done_o)
		else $error("access answered before fuses latched");
	region0_read_a: assert property (acc_valid_i && state_q == cfpb_pkg::ST_RUN
		&& acc_kind_i == 2'h0 && !acc_eeprom_i && acc_addr_i == 22'h00_0800
		&& !code_protect_low_q[0] |=> acc_done_o && !acc_grant_o)
		else $error("read of protected region zero granted");
	eeprom_read_a: assert property (acc_valid_i && state_q == cfpb_pkg::ST_RUN
		&& acc_kind_i == 2'h0 && acc_eeprom_i |=>
		acc_grant_o == $past(code_protect_high_q[cfpb_pkg::EEP_BIT]))
		else $error("eeprom read grant wrong");
	boot_write_a: assert property (acc_valid_i && state_q == cfpb_pkg::ST_RUN
		&& acc_kind_i == 2'h1 && !acc_eeprom_i && acc_addr_i <= cfpb_pkg::BOOT_END |=>
		acc_grant_o == $past(write_protect_high_q[cfpb_pkg::BOOT_BIT]))
		else $error("boot write grant wrong");
	table_same_a: assert property (acc_valid_i && state_q == cfpb_pkg::ST_RUN
		&& acc_kind_i == 2'h2 && !acc_eeprom_i && tgt_rg == exe_rg |=> acc_grant_o)
		else $error("table read inside own region refused");
	cfg_locked_a: assert property (psel_i && !penable_i && pwrite_i && !pready_q
		&& state_q == cfpb_pkg::ST_RUN && !write_protect_high_q[cfpb_pkg::CFG_BIT]
		|=> pready_o && pslverr_o ##1 !pready_o)
		else $error("write to locked config space not refused");
	id_read_a: assert property (psel_i && !penable_i && !pwrite_i && !pready_q
		&& state_q == cfpb_pkg::ST_RUN && reg_idx == cfpb_pkg::IDX_ID
		|=> pready_o && prdata_o == {24'h00_0000, PART_CODE, REVISION})
		else $error("id byte read wrong");
	stack_reset_a: assert property (stack_fault_i && stack_fault_reset_enable_o
		&& $stable(debug_option_config_q) |=> stack_reset_o)
		else $error("stack fault did not reset");
	mcu_mux_a: assert property (proc_mode_i == cfpb_pkg::MODE_MCU
		&& !capture2_mux_q[cfpb_pkg::MUX_BIT] |=> capture2_porte_pin7_o
		&& !capture2_portb_pin3_o && !capture2_portc_pin1_o)
		else $error("capture unit two misrouted");
	low_read_a: assert property (acc_valid_i && state_q == cfpb_pkg::ST_RUN
		&& acc_kind_i == 2'h0 && !acc_eeprom_i && acc_addr_i > cfpb_pkg::BOOT_END
		&& acc_addr_i <= cfpb_pkg::R3_END |=> acc_done_o
		&& acc_grant_o == $past(code_protect_low_q[acc_addr_i[15:14]]))
		else $error("region read grant wrong");
	low_write_a: assert property (acc_valid_i && state_q == cfpb_pkg::ST_RUN
		&& acc_kind_i == 2'h1 && !acc_eeprom_i && acc_addr_i > cfpb_pkg::BOOT_END
		&& acc_addr_i <= cfpb_pkg::R3_END |=> acc_done_o
		&& acc_grant_o == $past(write_protect_low_q[acc_addr_i[15:14]]))
		else $error("region write grant wrong");
	boot_read_a: assert property (acc_valid_i && state_q == cfpb_pkg::ST_RUN
		&& acc_kind_i == 2'h0 && !acc_eeprom_i && acc_addr_i <= cfpb_pkg::BOOT_END |=>
		acc_grant_o == $past(code_protect_high_q[cfpb_pkg::BOOT_BIT]))
		else $error("boot read grant wrong");
	eeprom_write_a: assert property (acc_valid_i && state_q == cfpb_pkg::ST_RUN
		&& acc_kind_i == 2'h1 && acc_eeprom_i |=>
		acc_grant_o == $past(write_protect_high_q[cfpb_pkg::EEP_BIT]))
		else $error("eeprom write grant wrong");
	cfg_write_a: assert property (acc_valid_i && state_q == cfpb_pkg::ST_RUN
		&& acc_kind_i == 2'h1 && !acc_eeprom_i && acc_addr_i >= cfpb_pkg::CFG_LO
		&& acc_addr_i <= cfpb_pkg::CFG_HI |=>
		acc_grant_o == $past(write_protect_high_q[cfpb_pkg::CFG_BIT]))
		else $error("config space write grant wrong");
	table_cross_a: assert property (acc_valid_i && state_q == cfpb_pkg::ST_RUN
		&& acc_kind_i == 2'h2 && !acc_eeprom_i && acc_addr_i > cfpb_pkg::BOOT_END
		&& acc_addr_i <= cfpb_pkg::R3_END && exec_addr_i[21:14] != acc_addr_i[21:14] |=>
		acc_grant_o == $past(table_read_protect_low_q[acc_addr_i[15:14]]))
		else $error("cross-region table read grant wrong");
	table_boot_a: assert property (acc_valid_i && state_q == cfpb_pkg::ST_RUN
		&& acc_kind_i == 2'h2 && !acc_eeprom_i && acc_addr_i <= cfpb_pkg::BOOT_END
		&& exec_addr_i > cfpb_pkg::BOOT_END |=>
		acc_grant_o == $past(table_read_protect_high_q[cfpb_pkg::BOOT_BIT]))
		else $error("boot table read grant wrong");
	reserved_kind_a: assert property (acc_valid_i && state_q == cfpb_pkg::ST_RUN
		&& acc_kind_i == 2'h3 |=> acc_done_o && !acc_grant_o)
		else $error("reserved access kind granted");
	option_pins_a: assert property ($past(rstn_i) |->
		debug_enable_o == !$past(debug_option_config_q[cfpb_pkg::DBG_BIT])
		&& portb_pin67_debug_o == debug_enable_o
		&& low_voltage_prog_enable_o == $past(debug_option_config_q[cfpb_pkg::LOWV_BIT]))
		else $error("option outputs do not follow option byte");
	ext_mux_a: assert property (proc_mode_i != cfpb_pkg::MODE_MCU
		&& !capture2_mux_q[cfpb_pkg::MUX_BIT] |=> capture2_portb_pin3_o
		&& !capture2_porte_pin7_o && !capture2_portc_pin1_o)
		else $error("capture unit two misrouted in external mode");
	portc_mux_a: assert property (capture2_mux_q[cfpb_pkg::MUX_BIT] |=>
		capture2_portc_pin1_o && !capture2_portb_pin3_o && !capture2_porte_pin7_o)
		else $error("capture unit two not on port C");
	loaded_flag_a: assert property (state_q == cfpb_pkg::ST_RUN |=> config_loaded_o)
		else $error("loaded flag missing");
	id_write_a: assert property (psel_i && !penable_i && pwrite_i && !pready_q
		&& state_q == cfpb_pkg::ST_RUN && reg_idx == cfpb_pkg::IDX_ID
		|=> pready_o && pslverr_o)
		else $error("write to id byte not refused");
endmodule
`default_nettype wire

/* File: tb/cfpb_programmer.sv */
// Programmer model: an APB master that reads and clears configuration bytes.
// Assumes one clock shared with the bank and a slave that may add wait states.
`timescale 1ns/10ps
`default_nettype none
module cfpb_programmer (
	input wire logic clk_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	input wire logic [31:0] prdata_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [23:0] paddr_o,
	output logic [31:0] pwdata_o,
	output logic [3:0] pstrb_o
);
	// Board keeps master clear enabled, so the entry pin needs no hold
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 24'h00_0000;
		pwdata_o = 32'h0000_0000;
		pstrb_o = 4'hf;
	end
	// Callers also write option bytes and try to set cleared protection bits through this transfer
	task automatic xfer(input logic wr, input logic [21:0] idx, input logic [7:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= wr;
		paddr_o <= {idx, 2'b00};
		pwdata_o <= {24'h00_0000, wd};
		@(posedge clk_i);
		penable_o <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (pready_i === 1'b1) break;
		end
		rd = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~paddr_o;
		pwdata_o <= ~pwdata_o;
	endtask
endmodule
`default_nettype wire

/* File: tb/cfpb_bank_bench.sv */
// Testbench for the configuration fuse protection bank.
// Assumes the programmer model drives APB; fuse levels are held from time zero.
`timescale 1ns/10ps
`default_nettype none
module cfpb_bank_bench;
	localparam logic [2:0] ID_PART = 3'h2; // Value is arbitrary
	localparam logic [4:0] ID_REV = 5'h0a; // Value is arbitrary
	logic core_clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [23:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic [3:0] pstrb_i;
	logic [7:0] fuse_capture2_mux_i = 8'hff, fuse_debug_option_i = 8'hff;
	logic [7:0] fuse_code_protect_low_i = 8'hfe, fuse_code_protect_high_i = 8'hff;
	logic [7:0] fuse_write_protect_low_i = 8'hff, fuse_write_protect_high_i = 8'hff;
	logic [7:0] fuse_table_read_protect_low_i = 8'hfd, fuse_table_read_protect_high_i = 8'hbf;
	logic acc_valid_i, acc_eeprom_i, acc_done_o, acc_grant_o, stack_fault_i, stack_reset_o;
	logic [1:0] acc_kind_i, proc_mode_i;
	logic [21:0] acc_addr_i, exec_addr_i;
	logic config_loaded_o, debug_enable_o, portb_pin67_debug_o, low_voltage_prog_enable_o;
	logic stack_fault_reset_enable_o, capture2_portc_pin1_o, capture2_portb_pin3_o;
	logic capture2_porte_pin7_o;
	int n_errors = 0;
	int check_count = 0;
	logic [21:0] ridx [9] = '{cfpb_pkg::IDX_MUX, cfpb_pkg::IDX_DBG, cfpb_pkg::IDX_CPL,
		cfpb_pkg::IDX_CPH, cfpb_pkg::IDX_WPL, cfpb_pkg::IDX_WPH, cfpb_pkg::IDX_TRL,
		cfpb_pkg::IDX_TRH, cfpb_pkg::IDX_ID};
	logic [7:0] rexp [9] = '{8'h01, 8'h85, 8'h0e, 8'hc0, 8'h0f, 8'he0, 8'h0d, 8'h00,
		{ID_PART, ID_REV}};
	cfpb_bank #(.PART_CODE(ID_PART), .REVISION(ID_REV)) uut (.core_clk_i, .rstn_i, .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
		.fuse_capture2_mux_i, .fuse_debug_option_i, .fuse_code_protect_low_i,
		.fuse_code_protect_high_i, .fuse_write_protect_low_i, .fuse_write_protect_high_i,
		.fuse_table_read_protect_low_i, .fuse_table_read_protect_high_i, .acc_valid_i,
		.acc_kind_i, .acc_eeprom_i, .acc_addr_i, .exec_addr_i, .acc_done_o, .acc_grant_o,
		.proc_mode_i, .stack_fault_i, .config_loaded_o, .debug_enable_o, .portb_pin67_debug_o,
		.low_voltage_prog_enable_o, .stack_fault_reset_enable_o, .stack_reset_o,
		.capture2_portc_pin1_o, .capture2_portb_pin3_o, .capture2_porte_pin7_o);
	cfpb_programmer prog (.clk_i(core_clk_i), .pready_i(pready_o), .pslverr_i(pslverr_o),
		.prdata_i(prdata_o), .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
		.paddr_o(paddr_i), .pwdata_o(pwdata_i), .pstrb_o(pstrb_i));
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xfer(input logic wr, input logic [21:0] idx, input logic [7:0] wd,
			input logic [7:0] exp, input logic xerr);
		logic [31:0] d;
		logic e;
		prog.xfer(wr, idx, wd, d, e);
		if (!wr) chk("read data", {24'h00_0000, exp}, d);
		chk("slave error", 32'(xerr), 32'(e));
	endtask
	task automatic acc(input logic [1:0] k, input logic e, input logic [21:0] a,
			input logic [21:0] x, input logic g);
		@(posedge core_clk_i);
		acc_valid_i <= 1'b1;
		acc_kind_i <= k;
		acc_eeprom_i <= e;
		acc_addr_i <= a;
		exec_addr_i <= x;
		@(posedge core_clk_i);
		acc_valid_i <= 1'b0;
		acc_addr_i <= ~a;
		#1;
		chk("access done", 32'h0000_0001, 32'(acc_done_o));
		chk("access grant", 32'(g), 32'(acc_grant_o));
	endtask
	task automatic settle(input logic [3:0] opts, input logic [2:0] mux);
		repeat (2) @(posedge core_clk_i);
		#1;
		chk("options", 32'(opts), 32'({debug_enable_o, portb_pin67_debug_o,
			low_voltage_prog_enable_o, stack_fault_reset_enable_o}));
		chk("capture2 route", 32'(mux), 32'({capture2_portc_pin1_o, capture2_portb_pin3_o,
			capture2_porte_pin7_o}));
	endtask
	task automatic sfault(input logic exp);
		@(posedge core_clk_i);
		stack_fault_i <= 1'b1;
		@(posedge core_clk_i);
		stack_fault_i <= 1'b0;
		#1;
		chk("stack reset", 32'(exp), 32'(stack_reset_o));
	endtask
	initial begin
		repeat (20000) @(posedge core_clk_i);
		n_errors++;
		test_done();
	end
	initial begin
		rstn_i <= 1'b0;
		acc_valid_i <= 1'b0;
		acc_kind_i <= 2'h0;
		acc_eeprom_i <= 1'b0;
		acc_addr_i <= 22'h00_0000;
		exec_addr_i <= 22'h00_0000;
		proc_mode_i <= cfpb_pkg::MODE_MCU;
		stack_fault_i <= 1'b0;
		repeat (6) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1;
		chk("loaded", 32'h0000_0001, 32'(config_loaded_o));
		settle(4'h3, 3'h4);
		for (int i = 0; i < 9; i++) begin
			xfer(1'b0, ridx[i], 8'h00, rexp[i], 1'b0);
		end
		xfer(1'b0, 22'h30_0007, 8'h00, 8'h00, 1'b1);
		xfer(1'b1, cfpb_pkg::IDX_ID, 8'h00, 8'h00, 1'b1);
		acc(2'h0, 1'b0, 22'h00_07ff, 22'h00_0000, 1'b1);
		acc(2'h0, 1'b0, 22'h00_0800, 22'h00_0000, 1'b0);
		acc(2'h0, 1'b0, 22'h00_3fff, 22'h00_0000, 1'b0);
		acc(2'h0, 1'b0, 22'h00_4000, 22'h00_0000, 1'b1);
		acc(2'h2, 1'b0, 22'h00_4000, 22'h00_0000, 1'b0);
		acc(2'h2, 1'b0, 22'h00_7fff, 22'h00_4100, 1'b1);
		acc(2'h2, 1'b0, 22'h00_0000, 22'h00_0800, 1'b0);
		acc(2'h2, 1'b0, 22'h00_07ff, 22'h00_0010, 1'b1);
		acc(2'h1, 1'b0, 22'h00_c000, 22'h00_0000, 1'b1);
		acc(2'h3, 1'b0, 22'h01_0000, 22'h00_0000, 1'b0);
		acc(2'h0, 1'b1, 22'h00_0000, 22'h00_0000, 1'b1);
		sfault(1'b1);
		xfer(1'b1, cfpb_pkg::IDX_DBG, 8'h00, 8'h00, 1'b0);
		settle(4'hc, 3'h4);
		sfault(1'b0);
		xfer(1'b1, cfpb_pkg::IDX_DBG, 8'h85, 8'h00, 1'b0);
		xfer(1'b1, cfpb_pkg::IDX_MUX, 8'h00, 8'h00, 1'b0);
		settle(4'h3, 3'h1);
		@(posedge core_clk_i);
		proc_mode_i <= 2'h0;
		settle(4'h3, 3'h2);
		xfer(1'b1, cfpb_pkg::IDX_MUX, 8'h01, 8'h00, 1'b0);
		settle(4'h3, 3'h4);
		xfer(1'b1, cfpb_pkg::IDX_CPL, 8'h0f, 8'h00, 1'b0);
		xfer(1'b0, cfpb_pkg::IDX_CPL, 8'h00, 8'h0e, 1'b0);
		xfer(1'b1, cfpb_pkg::IDX_CPL, 8'h0b, 8'h00, 1'b0);
		xfer(1'b0, cfpb_pkg::IDX_CPL, 8'h00, 8'h0a, 1'b0);
		xfer(1'b1, cfpb_pkg::IDX_CPH, 8'h00, 8'h00, 1'b0);
		xfer(1'b1, cfpb_pkg::IDX_WPL, 8'h0b, 8'h00, 1'b0);
		xfer(1'b1, cfpb_pkg::IDX_WPH, 8'h20, 8'h00, 1'b0);
		xfer(1'b0, cfpb_pkg::IDX_WPH, 8'h00, 8'h20, 1'b0);
		acc(2'h0, 1'b0, 22'h00_8000, 22'h00_0000, 1'b0);
		acc(2'h0, 1'b1, 22'h00_0000, 22'h00_0000, 1'b0);
		acc(2'h0, 1'b0, 22'h00_0000, 22'h00_0000, 1'b0);
		acc(2'h1, 1'b0, 22'h00_bfff, 22'h00_0000, 1'b0);
		acc(2'h1, 1'b0, 22'h00_7fff, 22'h00_0000, 1'b1);
		acc(2'h1, 1'b1, 22'h00_0000, 22'h00_0000, 1'b0);
		acc(2'h1, 1'b0, 22'h00_07ff, 22'h00_0000, 1'b0);
		acc(2'h1, 1'b0, 22'h30_0000, 22'h00_0000, 1'b1);
		xfer(1'b1, cfpb_pkg::IDX_WPH, 8'h00, 8'h00, 1'b0);
		acc(2'h1, 1'b0, 22'h30_00ff, 22'h00_0000, 1'b0);
		xfer(1'b1, cfpb_pkg::IDX_DBG, 8'h00, 8'h00, 1'b1);
		xfer(1'b0, cfpb_pkg::IDX_DBG, 8'h00, 8'h85, 1'b0);
		test_done();
	end
endmodule
`default_nettype wire
